//--- design/adct_top.sv
// Summary of operation
// - Sample phase precedes any bit decision
// - Ten approximation steps, one bit each
// - Four equalizing steps follow the decisions
// - Each converting step lasts one conv_clock_period
// - Timing fields sit in top four bits
// - Conv clock: 24, 96, 48 units
// - Sample clock is conv clock times 1,2,4,8
// - Sampling lasts two sample clock periods
// - Total: 14 tcc, 2 tsc, 4 units
// - Total includes sample, steps, result load
// - Input ignored after sampling ends
// - Out of range gives zeros or ones
// - Timing unit is half a CPU period
`timescale 1ns/1ps
`include "adct_params.svh"

module adct_top (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        start,
  input  wire logic [`ADCT_CTRL_W-1:0]     converter_control_register,
  input  wire logic                        cmp_above,
  output wire logic                        sample_en,
  output wire logic [`ADCT_RES_W-1:0]      dac_code,
  output wire logic                        busy,
  output wire logic [`ADCT_RES_W-1:0]      result,
  output wire logic                        done
);
  import adct_pkg::*;

  adct_state_t st;       // Registered state
  adct_state_t next_st;  // Next state
  adct_sar_if  sif ();   // Link to the approximation register

  // Clock cycles per conv_clock_period for a select code
  function automatic logic [`ADCT_CNT_W-1:0] tcc_cycles(
    input logic [1:0] ctc
  );
    logic [`ADCT_CNT_W-1:0] half_cpu_period_unit;
    half_cpu_period_unit = `ADCT_CNT_W'(`ADCT_TCC_TCL_FAST);
    unique case (ctc)
      // Slow base clock
      `ADCT_CTC_SLOW: half_cpu_period_unit = `ADCT_CNT_W'(`ADCT_TCC_TCL_SLOW);
      // Medium base clock
      `ADCT_CTC_MID:  half_cpu_period_unit = `ADCT_CNT_W'(`ADCT_TCC_TCL_MID);
      // Fast base clock; reserved code treated the same
      `ADCT_CTC_FAST,
      `ADCT_CTC_RSVD: half_cpu_period_unit = `ADCT_CNT_W'(`ADCT_TCC_TCL_FAST);
    endcase
    // Two half periods make one clock cycle
    return half_cpu_period_unit / `ADCT_CNT_W'(`ADCT_TCL_PER_CLK);
  endfunction

  // Clock cycles of the whole sample phase
  function automatic logic [`ADCT_CNT_W-1:0] sample_cycles(
    input logic [1:0] ctc,
    input logic [1:0] stc
  );
    logic [`ADCT_CNT_W-1:0] tsc;
    // Sample clock is the base clock times two to the code
    tsc = tcc_cycles(ctc) << stc;
    return `ADCT_CNT_W'(tsc * `ADCT_CNT_W'(`ADCT_SAMPLE_PERIODS));
  endfunction

  // Cycles spent loading the result register
  localparam logic [`ADCT_CNT_W-1:0] LOAD_CYCLES =
    `ADCT_CNT_W'(`ADCT_LOAD_TCL / `ADCT_TCL_PER_CLK);

  // Number of bit decision steps
  localparam logic [`ADCT_IDX_W-1:0] DECIDE_STEPS =
    `ADCT_IDX_W'(`ADCT_DECIDE_STEPS);

  // Conversion clock select field of a control word
  function automatic logic [1:0] ctc_field(
    input logic [`ADCT_CTRL_W-1:0] word
  );
    // Upper pair of the top four bits
    return word[`ADCT_CTC_HI:`ADCT_CTC_LO];
  endfunction

  // Sample clock select field of a control word
  function automatic logic [1:0] stc_field(
    input logic [`ADCT_CTRL_W-1:0] word
  );
    // Lower pair of the top four bits
    return word[`ADCT_STC_HI:`ADCT_STC_LO];
  endfunction

  // Load value of a down counter that must run a number of cycles
  function automatic logic [`ADCT_CNT_W-1:0] last_index(
    input logic [`ADCT_CNT_W-1:0] cycles
  );
    // The counter expires on the edge at which it reads zero
    return cycles - `ADCT_CNT_W'(1);
  endfunction

  // One cycle less on a running down counter
  function automatic logic [`ADCT_CNT_W-1:0] count_down(
    input logic [`ADCT_CNT_W-1:0] cnt
  );
    // Never called at zero; the phase moves on there instead
    return cnt - `ADCT_CNT_W'(1);
  endfunction

  // Bit decided in a given decision step, top bit first
  function automatic logic [`ADCT_IDX_W-1:0] decide_bit(
    input logic [`ADCT_IDX_W-1:0] step
  );
    // First step decides the top bit, last step the bottom bit
    return DECIDE_STEPS - `ADCT_IDX_W'(1) - step;
  endfunction

  // Approximation register
  adct_sar u_sar (
    .ref_clk (ref_clk),
    .rst     (rst),
    .sif     (sif.sar)
  );

  // Switch control straight from its flop
  assign sample_en = st.sample_en;
  // Trial code held in the approximation register
  assign dac_code  = sif.trial;
  // Handshake level, decoded from the phase flops
  assign busy      = (st.phase != ADCT_IDLE);
  // Result register and completion pulse
  assign result    = st.result;
  assign done      = st.done;

  // Comparator only counts during decisions
  assign sif.cmp = st.sync2;

  // Sequencer: works out the next state from the present one
  always_comb begin
    // Hold everything unless a branch below says otherwise
    next_st         = st;
    // Completion is a single cycle pulse
    next_st.done    = 1'b0;
    // Comparator crosses in through two flops
    next_st.sync1   = cmp_above;
    next_st.sync2   = st.sync1;
    // Approximation register idles unless told
    sif.clear       = 1'b0;
    sif.decide      = 1'b0;
    // Bit index counts down from the top bit
    sif.bit_idx     = decide_bit(st.step);
    unique case (st.phase)
      // Wait for a start request
      ADCT_IDLE: begin
        if (start) begin
          // Take the timing fields from the upper bits
          next_st.ctc = ctc_field(converter_control_register);
          next_st.stc = stc_field(converter_control_register);
          // Close the switch; sampling starts at once
          next_st.phase     = ADCT_SAMPLE;
          next_st.sample_en = 1'b1;
          // Sample length follows the word being taken
          next_st.cnt = last_index(sample_cycles(
            ctc_field(converter_control_register),
            stc_field(converter_control_register)));
          // Preset the trial code for the first decision
          sif.clear = 1'b1;
        end else begin
          // Stay idle; the control word is not looked at
          next_st.phase = ADCT_IDLE;
        end
      end
      // Capacitors track the input
      ADCT_SAMPLE: begin
        if (st.cnt == '0) begin
          // Open the switch; input no longer matters
          next_st.sample_en = 1'b0;
          next_st.phase     = ADCT_CONVERT;
          // First converting step is a decision step
          next_st.step      = '0;
          next_st.cnt       = last_index(tcc_cycles(st.ctc));
        end else begin
          // Keep sampling
          next_st.cnt = count_down(st.cnt);
        end
      end
      // Decision steps then equalizing steps
      ADCT_CONVERT: begin
        if (st.cnt == '0) begin
          // Decide at the end of the step, settled comparator
          if (st.step < DECIDE_STEPS) begin
            sif.decide = 1'b1;
          end
          if (st.step == `ADCT_LAST_STEP) begin
            // Fourteen steps done, go load the result
            next_st.phase = ADCT_LOAD;
            next_st.cnt   = last_index(LOAD_CYCLES);
          end else begin
            // Next step, one base clock period long
            next_st.step = st.step + `ADCT_IDX_W'(1);
            next_st.cnt  = last_index(tcc_cycles(st.ctc));
          end
        end else begin
          // Step still running
          next_st.cnt = count_down(st.cnt);
        end
      end
      // Transfer to the result register
      ADCT_LOAD: begin
        if (st.cnt == '0) begin
          // Result and completion on the same edge
          next_st.result = sif.trial;
          next_st.done   = 1'b1;
          next_st.phase  = ADCT_IDLE;
        end else begin
          // Transfer still settling
          next_st.cnt = count_down(st.cnt);
        end
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

//--- design/adct_params.svh
`ifndef ADCT_PARAMS_SVH
`define ADCT_PARAMS_SVH

// Field positions of the timing fields in the control word
`define ADCT_CTRL_W          16
`define ADCT_CTC_HI          15
`define ADCT_CTC_LO          14
`define ADCT_STC_HI          13
`define ADCT_STC_LO          12

// Conversion clock select codes
`define ADCT_CTC_FAST        2'h0
`define ADCT_CTC_RSVD        2'h1
`define ADCT_CTC_SLOW        2'h2
`define ADCT_CTC_MID         2'h3

// Times in half CPU periods (half_cpu_period_unit)
`define ADCT_TCC_TCL_FAST    24
`define ADCT_TCC_TCL_MID     48
`define ADCT_TCC_TCL_SLOW    96
`define ADCT_LOAD_TCL        4
`define ADCT_TCL_PER_CLK     2

// Step and phase counts
`define ADCT_SAMPLE_PERIODS  2
`define ADCT_DECIDE_STEPS    10
`define ADCT_LAST_STEP       4'hd

// Widths and reset values
`define ADCT_RES_W           10
`define ADCT_CNT_W           12
`define ADCT_IDX_W           4
`define ADCT_RESULT_RST      10'h000
`define ADCT_SAR_START       10'h200

`endif

//--- design/adct_pkg.sv
`include "adct_params.svh"

package adct_pkg;

  // Phases of one conversion
  typedef enum logic [1:0] {
    ADCT_IDLE,
    ADCT_SAMPLE,
    ADCT_CONVERT,
    ADCT_LOAD
  } adct_phase_t;

  // Whole state of the sequencer
  typedef struct packed {
    adct_phase_t                 phase;     // Current phase
    logic [`ADCT_CNT_W-1:0]      cnt;       // Cycles left in this step
    logic [`ADCT_IDX_W-1:0]      step;      // Converting step index
    logic [1:0]                  ctc;       // Latched conv_clock_select
    logic [1:0]                  stc;       // Latched sample_clock_select
    logic [`ADCT_RES_W-1:0]      result;    // Result register
    logic                        done;      // Completion pulse
    logic                        sample_en; // Sampling switch closed
    logic                        sync1;     // Comparator sync stage 1
    logic                        sync2;     // Comparator sync stage 2
  } adct_state_t;

  // Whole state of the approximation register
  typedef struct packed {
    logic [`ADCT_RES_W-1:0]      trial;     // Trial and final code
  } adct_sar_state_t;

endpackage

//--- design/adct_sar_if.sv
`timescale 1ns/1ps
`include "adct_params.svh"

interface adct_sar_if;
  logic                       clear;      // Preset the trial code
  logic                       decide;     // Take one bit decision
  logic                       cmp;        // Input above trial level
  logic [`ADCT_IDX_W-1:0]     bit_idx;    // Bit being decided
  logic [`ADCT_RES_W-1:0]     trial;      // Current trial code

  modport ctrl (output clear, decide, cmp, bit_idx, input trial);
  modport sar  (input clear, decide, cmp, bit_idx, output trial);
endinterface

//--- design/adct_sar.sv
`timescale 1ns/1ps
`include "adct_params.svh"

module adct_sar (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  adct_sar_if.sar    sif
);
  import adct_pkg::*;

  adct_sar_state_t st;       // Registered state
  adct_sar_state_t next_st;  // Next state

  // Trial code drives the capacitor array directly
  assign sif.trial = st.trial;

  // One bit decided per step, from the top bit down
  always_comb begin
    next_st = st;
    if (sif.clear) begin
      // Start with only the top bit set
      next_st.trial = `ADCT_SAR_START;
    end else if (sif.decide) begin
      // Drop the bit when the input lies below the trial level
      if (!sif.cmp) begin
        next_st.trial[sif.bit_idx] = 1'b0;
      end
      // Try the next lower bit
      if (sif.bit_idx != '0) begin
        next_st.trial[sif.bit_idx - 4'h1] = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

//--- verif/adct_properties.sv
`timescale 1ns/1ps
`include "adct_params.svh"

module adct_properties (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    start,
  input wire logic [`ADCT_CTRL_W-1:0] converter_control_register,
  input wire logic                    cmp_above,
  input wire logic                    sample_en,
  input wire logic [`ADCT_RES_W-1:0]  dac_code,
  input wire logic                    busy,
  input wire logic [`ADCT_RES_W-1:0]  result,
  input wire logic                    done
);
  default clocking cb @(posedge ref_clk); endclocking
  // Reset seen one edge late, so the release edge is masked as well
  logic                   rst_q;
  default disable iff (rst || rst_q);
  logic [3:0]             fld;   // Fields taken at start
  logic [11:0]            s_cnt; // Cycles of sampling
  logic [11:0]            b_cnt; // Cycles busy
  logic [11:0]            q_cnt; // Cycles trial code unchanged
  logic [`ADCT_RES_W-1:0] dac_q; // Last trial code
  int                     c;     // Step length in cycles
  int                     s;     // Sample length in cycles
  int                     n;     // Busy length in cycles
  // Expected figures from the latched fields
  always_comb begin
    c = (fld[3:2] == 2'h2) ? 48 : (fld[3:2] == 2'h3) ? 24 : 12;
    s = (2 * c) << fld[1:0];
    n = s + 14 * c + 2;
  end
  // Helper counters
  always_ff @(posedge ref_clk) begin
    if (start && !busy) fld <= converter_control_register[15:12];
    s_cnt <= sample_en ? s_cnt + 12'h1 : 12'h0;
    b_cnt <= busy ? b_cnt + 12'h1 : 12'h0;
    q_cnt <= (dac_code == dac_q) ? q_cnt + 12'h1 : 12'h0;
    dac_q <= dac_code;
    rst_q <= rst;
  end
  sequence s_accept;
    start && !busy;
  endsequence
  sequence s_open;
    busy && sample_en && dac_code == 10'h200;
  endsequence
  a_start_opens: assert property (s_accept |=> s_open)
    else $error("conversion did not open with sampling");
  a_idle_quiet: assert property (!busy |-> !sample_en)
    else $error("sampling while idle");
  a_sample_len: assert property ($fell(sample_en) |-> s_cnt == s)
    else $error("sample phase length wrong");
  a_total_len: assert property (done |-> b_cnt == n)
    else $error("conversion length wrong");
  a_equalize_hold: assert property (done |-> q_cnt >= 4 * c)
    else $error("trial code moved in equalizing steps");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_busy: assert property (done |-> !busy && $past(busy))
    else $error("done not at end of busy");
  a_result_hold: assert property (!done |-> $stable(result))
    else $error("result moved without done");
endmodule

bind adct_top adct_properties u_props (
  .ref_clk(ref_clk), .rst(rst), .start(start),
  .converter_control_register(converter_control_register),
  .cmp_above(cmp_above), .sample_en(sample_en), .dac_code(dac_code),
  .busy(busy), .result(result), .done(done));

//--- verif/adct_ain_model.sv
`timescale 1ns/1ps
`include "adct_params.svh"

module adct_ain_model (
  input  wire logic                   sample_en,
  input  wire logic signed [11:0]     ain,
  input  wire logic [`ADCT_RES_W-1:0] dac_code,
  output wire logic                   cmp_above
);
  logic signed [11:0] held; // Level on the capacitor
  // Capacitor tracks the pin only while the switch is closed
  always_latch begin
    if (sample_en) held <= ain;
  end
  // Comparator saturates naturally outside the code range
  assign cmp_above = held >= $signed({2'b00, dac_code});
endmodule

//--- verif/adct_top_tb.sv
`timescale 1ns/1ps
`include "adct_params.svh"

module adct_top_tb;
  logic                    ref_clk;
  logic                    rst;
  logic                    start;
  logic [`ADCT_CTRL_W-1:0] ctl;
  logic                    cmp_above;
  logic                    sample_en;
  logic [`ADCT_RES_W-1:0]  dac_code;
  logic                    busy;
  logic [`ADCT_RES_W-1:0]  result;
  logic                    done;
  logic signed [11:0]      ain;
  int                      num_errors;
  int                      samples_checked;
  adct_top u_dut (.ref_clk(ref_clk), .rst(rst), .start(start),
    .converter_control_register(ctl), .cmp_above(cmp_above),
    .sample_en(sample_en), .dac_code(dac_code), .busy(busy),
    .result(result), .done(done));
  adct_ain_model u_ain (.sample_en(sample_en), .ain(ain),
    .dac_code(dac_code), .cmp_above(cmp_above));
  // Free running clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One conversion; pin moves to lv2 after sampling, a start is
  // poked mid-run and the fields scrambled, both must be ignored
  task automatic run_conv(input logic [15:0] cw,
                          input logic signed [11:0] lv, lv2);
    int c, n, cnt;
    logic [9:0] er;
    bit off;
    c = (cw[15:14] == 2'h2) ? 48 : (cw[15:14] == 2'h3) ? 24 : 12;
    n = ((2 * c) << cw[13:12]) + 14 * c + 2;
    er = (lv < 0) ? 10'h000 : (lv > 1023) ? 10'h3ff : lv[9:0];
    cnt = 0;
    off = 1'b0;
    @(posedge ref_clk);
    ain <= lv;
    ctl <= cw;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    ctl <= ~cw;
    do begin
      @(posedge ref_clk);
      cnt++;
      start <= (cnt == 5);
      if (off) ain <= lv2;
      @(negedge ref_clk);
      off = (sample_en === 1'b0);
    end while (done !== 1'b1 && cnt < 3000);
    if (cnt >= 3000) begin
      num_errors++;
      wrap_up();
    end
    check("cycles", cnt, n);
    check("result", result, er);
    check("busy", busy, 1'b0);
  endtask
  task automatic t_codes;
    for (int k = 0; k < 4; k++)
      run_conv({k[1:0], 14'h0}, 12'sd700, 12'sd700);
    for (int k = 1; k < 4; k++)
      run_conv({2'h3, k[1:0], 12'h0}, 12'sd341, 12'sd341);
  endtask
  task automatic t_hold;
    run_conv(16'h0000, 12'sd300, 12'sd900);
    run_conv(16'h2000, 12'sd900, 12'sd5);
  endtask
  task automatic t_range;
    run_conv(16'h4000, -12'sd40, -12'sd40);
    run_conv(16'hc000, 12'sd1500, 12'sd1500);
    run_conv(16'h0000, 12'sd1023, 12'sd0);
    run_conv(16'h0000, 12'sd0, 12'sd1023);
  endtask
  // Reset in mid conversion clears everything, then a clean run
  task automatic t_reset;
    run_conv(16'h0000, 12'sd777, 12'sd777);
    @(posedge ref_clk);
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check("busy", busy, 1'b0);
    check("sample_en", sample_en, 1'b0);
    check("result", result, 10'h000);
    check("dac_code", dac_code, 10'h000);
    check("done", done, 1'b0);
    run_conv(16'h0000, 12'sd512, 12'sd512);
  endtask
  // Main sequence
  initial begin
    num_errors = 0;
    samples_checked = 0;
    rst = 1'b1;
    start = 1'b0;
    ctl = 16'h0000;
    ain = 12'sd0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    t_codes();
    t_hold();
    t_range();
    t_reset();
    wrap_up();
  end
endmodule
